// ---- shared/cnc_pkg.sv ----
// Overview of operation
// - Port is slave only and works up to 100 kHz and 400 kHz clocks.
// - Data falling while clock high is a START; every transfer begins with one.
// - Data rising while clock high is a STOP; it ends the transfer.
// - Data changes only while clock low, stable while high, one pulse per bit.
// - Bytes of eight bits, MSB first, each followed by a ninth acknowledge clock.
// - Acknowledging receiver holds data low across the whole ninth clock high time.
// - On master not-acknowledge after a sent byte the port releases data.
// - Clock held low 35 ms resets the port and releases data; master keeps under 25 ms.
// - Clock-low timeout works only while the oscillator runs.
// - First byte after START is 110100, select bit, then direction bit.
// - Lowest address bit is compared with the select pin; a match is acknowledged.
// - Direction zero writes into the port, direction one reads from it.
// - In a write the first byte loads the pointer, later bytes are stored.
// - Every received byte of a transfer whose address matches is acknowledged: address, pointer and data.
// - Reads start at the pointer, which keeps its last value between transfers.
// - A repeated START ends one transfer and begins the next.
// - Byte count per transfer is unlimited and set by the master.
// - Oscillator runs when the disable bit is zero and stops when one.
package cnc_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int STD_SCL_HZ = 100_000;
   localparam int FAST_SCL_HZ = 400_000;
   localparam int TMO_LONG_MS = 35;
   localparam int TMO_SHORT_MS = 25;
   // Least time, exact here, so no rounding is lost
   localparam int TMO_CYC = ((CLK_HZ + 999) / 1000) * TMO_LONG_MS;
   // ---------------------------------------------------------------
   // Address byte layout
   // ---------------------------------------------------------------
   localparam logic [5:0] ADDR_HI = 6'h34;
   localparam int ADDR_HI_POS = 2;
   localparam int ADDR_SEL_POS = 1;
   localparam int DIR_POS = 0;
   localparam logic DIR_READ = 1'b1;
   localparam logic [3:0] BYTE_DONE = 4'h8;
   localparam logic [3:0] ACK_DONE = 4'h9;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cnc_acc_t;
   typedef enum logic [2:0] {
      st_idle, st_addr, st_ack_addr, st_rx, st_ack_rx, st_tx, st_tx_ack
   } cnc_state_t;
endpackage

// ---- rtl/cnc_xfer.sv ----
`timescale 1ns/1ns
module cnc_xfer #(
   parameter int DW = 8
) (
   input wire logic s_clk,
   input wire logic s_rst_b,
   input wire logic s_ce,
   input wire logic s_req,
   input cnc_pkg::cnc_acc_t s_payload,
   output logic s_done,
   output logic [DW-1:0] s_rdata,
   input wire logic d_clk,
   input wire logic d_rst_b,
   input wire logic d_ce,
   output logic d_valid,
   output cnc_pkg::cnc_acc_t d_payload,
   input wire logic [DW-1:0] d_rdata
);
   // ---------------------------------------------------------------
   // Source side: toggle out, payload held until the ack returns
   // ---------------------------------------------------------------
   logic req_tgl_r, req_tgl_nxt;
   cnc_pkg::cnc_acc_t pl_r, pl_nxt;
   logic [2:0] ack_sy_r, ack_sy_nxt;
   logic ack_tgl_r, ack_tgl_nxt;
   logic [DW-1:0] rdat_r, rdat_nxt;
   logic [2:0] req_sy_r, req_sy_nxt;

   assign s_done = ack_sy_r[1] ^ ack_sy_r[2];
   assign s_rdata = rdat_r;

   always_comb begin
      req_tgl_nxt = req_tgl_r;
      pl_nxt = pl_r;
      ack_sy_nxt = {ack_sy_r[1:0], ack_tgl_r};
      if (s_ce && s_req) begin
         req_tgl_nxt = ~req_tgl_r;
         pl_nxt = s_payload;
      end
      // Edge stage waits while frozen so no completion is lost
      if (!s_ce) begin
         ack_sy_nxt[2] = ack_sy_r[2];
      end
   end

   always_ff @(posedge s_clk) begin
      if (!s_rst_b) begin
         req_tgl_r <= 1'b0;
         pl_r <= '0;
         ack_sy_r <= 3'h0;
      end else begin
         req_tgl_r <= req_tgl_nxt;
         pl_r <= pl_nxt;
         ack_sy_r <= ack_sy_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Destination side: one pulse per toggle, answer captured
   // ---------------------------------------------------------------
   assign d_valid = (req_sy_r[1] ^ req_sy_r[2]) & d_ce;
   assign d_payload = pl_r;

   always_comb begin
      req_sy_nxt = {req_sy_r[1:0], req_tgl_r};
      ack_tgl_nxt = ack_tgl_r;
      rdat_nxt = rdat_r;
      if (!d_ce) begin
         req_sy_nxt[2] = req_sy_r[2];
      end
      if (d_valid) begin
         rdat_nxt = d_rdata;
         ack_tgl_nxt = ~ack_tgl_r;
      end
   end

   always_ff @(posedge d_clk) begin
      if (!d_rst_b) begin
         req_sy_r <= 3'h0;
         ack_tgl_r <= 1'b0;
         rdat_r <= '0;
      end else begin
         req_sy_r <= req_sy_nxt;
         ack_tgl_r <= ack_tgl_nxt;
         rdat_r <= rdat_nxt;
      end
   end
endmodule

// ---- rtl/cnc_i2c_slave.sv ----
`timescale 1ns/1ns
module cnc_i2c_slave #(
   parameter int TMO_CYC = cnc_pkg::TMO_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic lnk_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic address_select_pin,
   input wire logic oscillator_disable_bit,
   output logic acc_valid,
   output cnc_pkg::cnc_acc_t acc,
   input wire logic [7:0] acc_rdata,
   output logic port_busy,
   output logic port_timeout
);
   localparam int TW = $clog2(TMO_CYC + 1);
   localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYC - 1);

   // ---------------------------------------------------------------
   // Clock-low timeout on the system clock
   // ---------------------------------------------------------------
   logic [1:0] scl_c_r;
   logic [TW-1:0] tmo_cnt_r, tmo_cnt_nxt;
   logic tmo_r, tmo_nxt;
   logic busy_c_r [2];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_c_r <= 2'h3;
      end else begin
         scl_c_r <= {scl_c_r[0], scl_i};
      end
   end

   always_comb begin
      tmo_cnt_nxt = tmo_cnt_r;
      tmo_nxt = tmo_r;
      if (ce) begin
         // Stopped oscillator means no timebase, hence no timeout
         if (!oscillator_disable_bit && !scl_c_r[1]) begin
            if (tmo_cnt_r == TMO_LAST) begin
               tmo_nxt = 1'b1;
            end else begin
               tmo_cnt_nxt = tmo_cnt_r + TW'(1);
            end
         end else begin
            tmo_cnt_nxt = '0;
            tmo_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tmo_cnt_r <= '0;
         tmo_r <= 1'b0;
      end else begin
         tmo_cnt_r <= tmo_cnt_nxt;
         tmo_r <= tmo_nxt;
      end
   end

   assign port_timeout = tmo_r;

   // ---------------------------------------------------------------
   // Link-side synchronisers
   // ---------------------------------------------------------------
   // Order: rst_b, ce, timeout, select pin, sda, scl
   localparam int NS = 6;
   logic [NS-1:0] sy_in, sy_m_r, sy_s_r;
   logic l_rst_b, l_ce, l_tmo, l_sel, l_sda, l_scl;
   logic scl_q_r, sda_q_r;

   assign sy_in = {rst_b, ce, tmo_r, address_select_pin, sda_i, scl_i};

   always_ff @(posedge lnk_clk) begin
      sy_m_r <= sy_in;
      sy_s_r <= sy_m_r;
   end

   assign {l_rst_b, l_ce, l_tmo, l_sel, l_sda, l_scl} = sy_s_r;

   always_ff @(posedge lnk_clk) begin
      if (!l_rst_b) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else if (l_ce) begin
         scl_q_r <= l_scl;
         sda_q_r <= l_sda;
      end
   end

   // ---------------------------------------------------------------
   // Bus conditions
   // ---------------------------------------------------------------
   logic scl_rise, scl_fall, cond_start, cond_stop;

   // Sampling at 8 MHz gives twenty samples per bit at 400 kHz
   assign scl_rise = l_scl & ~scl_q_r;
   assign scl_fall = ~l_scl & scl_q_r;
   assign cond_start = l_scl & scl_q_r & sda_q_r & ~l_sda;
   assign cond_stop = l_scl & scl_q_r & ~sda_q_r & l_sda;

   // ---------------------------------------------------------------
   // Protocol engine
   // ---------------------------------------------------------------
   cnc_pkg::cnc_state_t st_r, st_nxt;
   logic [3:0] bits_r, bits_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic [7:0] txb_r, txb_nxt;
   logic rw_r, rw_nxt;
   logic ptr_ok_r, ptr_ok_nxt;
   logic oe_r, oe_nxt;
   logic req_r, req_nxt;
   cnc_pkg::cnc_acc_t pl_r, pl_nxt;
   logic x_done;
   logic [7:0] x_rdata;
   logic addr_hit;

   function automatic logic addr_match(input logic [7:0] b, input logic sel);
      addr_match = (b[7:cnc_pkg::ADDR_HI_POS] == cnc_pkg::ADDR_HI)
         && (b[cnc_pkg::ADDR_SEL_POS] == sel);
   endfunction

   assign addr_hit = addr_match(sh_r, l_sel);

   always_comb begin
      st_nxt = st_r;
      bits_nxt = bits_r;
      sh_nxt = sh_r;
      ptr_nxt = ptr_r;
      txb_nxt = txb_r;
      rw_nxt = rw_r;
      ptr_ok_nxt = ptr_ok_r;
      oe_nxt = oe_r;
      req_nxt = 1'b0;
      pl_nxt = pl_r;
      if (x_done) begin
         txb_nxt = x_rdata;
      end
      if (l_tmo) begin
         st_nxt = cnc_pkg::st_idle;
         oe_nxt = 1'b0;
      end else if (cond_start) begin
         st_nxt = cnc_pkg::st_addr;
         bits_nxt = 4'h0;
         oe_nxt = 1'b0;
      end else if (cond_stop) begin
         st_nxt = cnc_pkg::st_idle;
         oe_nxt = 1'b0;
      end else begin
         unique case (st_r)
            cnc_pkg::st_idle: begin
               oe_nxt = 1'b0;
            end
            cnc_pkg::st_addr: begin
               if (scl_rise) begin
                  sh_nxt = {sh_r[6:0], l_sda};
                  bits_nxt = bits_r + 4'h1;
               end else if (scl_fall && bits_r == cnc_pkg::BYTE_DONE) begin
                  if (addr_hit) begin
                     oe_nxt = 1'b1;
                     rw_nxt = sh_r[cnc_pkg::DIR_POS];
                     st_nxt = cnc_pkg::st_ack_addr;
                     if (sh_r[cnc_pkg::DIR_POS] == cnc_pkg::DIR_READ) begin
                        // Fetch early: a whole bit time is left for the crossing
                        req_nxt = 1'b1;
                        pl_nxt = '{wr: 1'b0, addr: ptr_r, wdata: cnc_pkg::BYTE_RST};
                     end
                  end else begin
                     st_nxt = cnc_pkg::st_idle;
                  end
               end
            end
            cnc_pkg::st_ack_addr: begin
               if (scl_fall) begin
                  bits_nxt = 4'h0;
                  if (rw_r == cnc_pkg::DIR_READ) begin
                     sh_nxt = txb_r;
                     oe_nxt = ~txb_r[7];
                     st_nxt = cnc_pkg::st_tx;
                  end else begin
                     oe_nxt = 1'b0;
                     ptr_ok_nxt = 1'b0;
                     st_nxt = cnc_pkg::st_rx;
                  end
               end
            end
            cnc_pkg::st_rx: begin
               if (scl_rise) begin
                  sh_nxt = {sh_r[6:0], l_sda};
                  bits_nxt = bits_r + 4'h1;
               end else if (scl_fall && bits_r == cnc_pkg::BYTE_DONE) begin
                  oe_nxt = 1'b1;
                  st_nxt = cnc_pkg::st_ack_rx;
                  if (!ptr_ok_r) begin
                     ptr_nxt = sh_r;
                     ptr_ok_nxt = 1'b1;
                  end else begin
                     req_nxt = 1'b1;
                     pl_nxt = '{wr: 1'b1, addr: ptr_r, wdata: sh_r};
                     ptr_nxt = ptr_r + 8'h01;
                  end
               end
            end
            cnc_pkg::st_ack_rx: begin
               if (scl_fall) begin
                  oe_nxt = 1'b0;
                  bits_nxt = 4'h0;
                  st_nxt = cnc_pkg::st_rx;
               end
            end
            cnc_pkg::st_tx: begin
               if (scl_rise) begin
                  bits_nxt = bits_r + 4'h1;
               end else if (scl_fall) begin
                  if (bits_r == cnc_pkg::BYTE_DONE) begin
                     oe_nxt = 1'b0;
                     st_nxt = cnc_pkg::st_tx_ack;
                     ptr_nxt = ptr_r + 8'h01;
                     req_nxt = 1'b1;
                     pl_nxt = '{wr: 1'b0, addr: ptr_r + 8'h01, wdata: cnc_pkg::BYTE_RST};
                  end else begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     oe_nxt = ~sh_r[6];
                  end
               end
            end
            cnc_pkg::st_tx_ack: begin
               if (scl_rise) begin
                  bits_nxt = bits_r + 4'h1;
                  sh_nxt[0] = l_sda;
               end else if (scl_fall && bits_r == cnc_pkg::ACK_DONE) begin
                  if (!sh_r[0]) begin
                     bits_nxt = 4'h0;
                     sh_nxt = txb_r;
                     oe_nxt = ~txb_r[7];
                     st_nxt = cnc_pkg::st_tx;
                  end else begin
                     // Released line lets the master place its STOP
                     oe_nxt = 1'b0;
                     st_nxt = cnc_pkg::st_idle;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge lnk_clk) begin
      if (!l_rst_b) begin
         st_r <= cnc_pkg::st_idle;
         bits_r <= 4'h0;
         sh_r <= cnc_pkg::BYTE_RST;
         ptr_r <= cnc_pkg::PTR_RST;
         txb_r <= cnc_pkg::BYTE_RST;
         rw_r <= 1'b0;
         ptr_ok_r <= 1'b0;
         oe_r <= 1'b0;
         req_r <= 1'b0;
         pl_r <= '0;
      end else if (l_ce) begin
         st_r <= st_nxt;
         bits_r <= bits_nxt;
         sh_r <= sh_nxt;
         ptr_r <= ptr_nxt;
         txb_r <= txb_nxt;
         rw_r <= rw_nxt;
         ptr_ok_r <= ptr_ok_nxt;
         oe_r <= oe_nxt;
         req_r <= req_nxt;
         pl_r <= pl_nxt;
      end
   end

   // Open drain: the port only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = oe_r;

   // ---------------------------------------------------------------
   // Busy indication back on the system clock
   // ---------------------------------------------------------------
   logic l_busy_r;

   always_ff @(posedge lnk_clk) begin
      if (!l_rst_b) begin
         l_busy_r <= 1'b0;
      end else if (l_ce) begin
         l_busy_r <= (st_nxt != cnc_pkg::st_idle);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_c_r[0] <= 1'b0;
         busy_c_r[1] <= 1'b0;
      end else if (ce) begin
         busy_c_r[0] <= l_busy_r;
         busy_c_r[1] <= busy_c_r[0];
      end
   end

   assign port_busy = busy_c_r[1];

   // ---------------------------------------------------------------
   // Register access crossing
   // ---------------------------------------------------------------
   cnc_xfer #(
      .DW(8)
   ) u_xfer (
      .s_clk(lnk_clk),
      .s_rst_b(l_rst_b),
      .s_ce(l_ce),
      .s_req(req_r),
      .s_payload(pl_r),
      .s_done(x_done),
      .s_rdata(x_rdata),
      .d_clk(clk),
      .d_rst_b(rst_b),
      .d_ce(ce),
      .d_valid(acc_valid),
      .d_payload(acc),
      .d_rdata(acc_rdata)
   );
endmodule

// ---- verification/cnc_chk_assertions.sv ----
`timescale 1ns/1ns
module cnc_chk #(
   parameter int TMO_CYC = cnc_pkg::TMO_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic lnk_clk,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic oscillator_disable_bit,
   input wire logic acc_valid,
   input cnc_pkg::cnc_acc_t acc,
   input wire logic port_timeout
);
   // ----
   // Raw clock-low length; it leads the design's synced count by a few cycles
   // ----
   int lc_r;
   int lc_nxt;
   always_comb begin
      lc_nxt = lc_r;
      if (scl_i || oscillator_disable_bit) begin
         lc_nxt = 0;
      end else if (lc_r < TMO_CYC + 64) begin
         lc_nxt = lc_r + 1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lc_r <= 0;
      end else begin
         lc_r <= lc_nxt;
      end
   end
   // ----
   // Properties
   // ----
   // Drive may only move while the clock is low, so an ack stays low through the high time
   chk_drive_low: assert property (@(posedge clk) disable iff (!rst_b)
      scl_i && $past(scl_i) |-> $stable(sda_oe) && !sda_o)
      else $error("data drive moved while clock high");
   chk_oe_scl_low: assert property (@(posedge lnk_clk) disable iff (!rst_b)
      $changed(sda_oe) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2))
      else $error("data drive changed near clock high");
   chk_acc_pulse: assert property (@(posedge clk) disable iff (!rst_b) acc_valid |=> !acc_valid)
      else $error("access request longer than one cycle");
   chk_acc_hold: assert property (@(posedge clk) disable iff (!rst_b)
      acc_valid |-> $stable(acc) ##1 $stable(acc))
      else $error("access fields moved around request");
   chk_tmo_min: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(port_timeout) |-> lc_r >= TMO_CYC)
      else $error("timeout too early");
   chk_tmo_max: assert property (@(posedge clk) disable iff (!rst_b)
      lc_r == TMO_CYC + 16 |-> port_timeout)
      else $error("timeout missing");
   chk_tmo_osc: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(port_timeout) |-> !oscillator_disable_bit && !$past(oscillator_disable_bit))
      else $error("timeout with oscillator stopped");
   chk_tmo_free: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(port_timeout) |-> ##[0:40] !sda_oe)
      else $error("data not released on timeout");
   chk_tmo_clear: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(scl_i) |-> ##[1:8] !port_timeout)
      else $error("timeout not cleared");
   cov_wr: cover property (@(posedge clk) acc_valid && acc.wr);
   cov_rd: cover property (@(posedge clk) acc_valid && !acc.wr);
   cov_tmo: cover property (@(posedge clk) $rose(port_timeout));
endmodule
bind cnc_i2c_slave cnc_chk #(.TMO_CYC(TMO_CYC)) u_cnc_chk (.clk(clk), .rst_b(rst_b), .lnk_clk(lnk_clk),
   .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .oscillator_disable_bit(oscillator_disable_bit),
   .acc_valid(acc_valid), .acc(acc), .port_timeout(port_timeout));

// ---- verification/cnc_mst.sv ----
`timescale 1ns/1ns
module cnc_mst (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'h1;
      sda_low = 1'h0;
   end
   // Quarter bit of 32 cycles keeps the clock just under 400 kHz; the low time clears the sync delay
   task automatic qw();
      repeat (32) @(negedge clk);
   endtask
   task automatic start();
      sda_low = 1'h0;
      qw();
      scl = 1'h1;
      qw();
      sda_low = 1'h1;
      qw();
      scl = 1'h0;
   endtask
   task automatic stop();
      qw();
      sda_low = 1'h1;
      qw();
      scl = 1'h1;
      qw();
      sda_low = 1'h0;
      qw();
   endtask
   task automatic bit_io(input logic b, output logic r);
      qw();
      sda_low = !b;
      qw();
      scl = 1'h1;
      qw();
      r = sda;
      qw();
      scl = 1'h0;
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ack_in, ack);
   endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   logic clk;
   logic lnk_clk;
   logic rst_b;
   logic osc_dis;
   logic asel;
   logic scl;
   logic sda_low;
   logic sda_oe;
   logic sda_o;
   logic sda;
   logic acc_valid;
   logic port_timeout;
   logic port_busy;
   cnc_pkg::cnc_acc_t acc;
   logic [7:0] acc_rdata;
   logic [7:0] regs [256];
   int ref_mem [256];
   int ptr;
   int mismatches;
   int compares;
   int seed;
   logic [7:0] rx;
   logic [7:0] ab;
   logic ack;
   // Open drain line with pull-up
   assign sda = !(sda_oe && !sda_o) && !sda_low;
   assign acc_rdata = regs[acc.addr];
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   initial begin
      lnk_clk = 1'h0;
      #7;
      forever begin
         #62 lnk_clk = 1'h1;
         #63 lnk_clk = 1'h0;
      end
   end
   always @(posedge clk) begin
      if (acc_valid && acc.wr) begin
         regs[acc.addr] <= acc.wdata;
      end
   end
   cnc_mst u_cnc_mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   cnc_i2c_slave #(.TMO_CYC(200)) u_cnc_i2c_slave (.clk(clk), .rst_b(rst_b), .ce(1'h1), .lnk_clk(lnk_clk),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(asel),
      .oscillator_disable_bit(osc_dis), .acc_valid(acc_valid), .acc(acc), .acc_rdata(acc_rdata),
      .port_busy(port_busy), .port_timeout(port_timeout));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic send(input logic [7:0] b, input logic acked);
      u_cnc_mst.byte_io(b, 1'h1, rx, ack);
      check({7'h00, ack}, {7'h00, !acked});
   endtask
   task automatic wr_ptr(input int p);
      u_cnc_mst.start();
      send({cnc_pkg::ADDR_HI, asel, 1'h0}, 1'h1);
      send(p[7:0], 1'h1);
      ptr = p & 255;
   endtask
   task automatic wr_data(input int n);
      for (int k = 0; k < n; k++) begin
         ref_mem[ptr] = $random(seed) & 255;
         send(ref_mem[ptr][7:0], 1'h1);
         ptr = (ptr + 1) & 255;
      end
   endtask
   task automatic rd_data(input int n);
      u_cnc_mst.start();
      send({cnc_pkg::ADDR_HI, asel, 1'h1}, 1'h1);
      for (int k = 0; k < n; k++) begin
         u_cnc_mst.byte_io(8'hff, k == n - 1, rx, ack);
         check(rx, ref_mem[ptr][7:0]);
         ptr = (ptr + 1) & 255;
      end
      repeat (25) @(negedge clk);
      check({7'h00, sda_oe}, 8'h00);
      u_cnc_mst.stop();
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      seed = 32'h08b6;
      rst_b = 1'h0;
      osc_dis = 1'h0;
      asel = 1'h0;
      mismatches = 0;
      compares = 0;
      for (int a = 0; a < 256; a++) begin
         ref_mem[a] = $random(seed) & 255;
         regs[a] = ref_mem[a][7:0];
      end
      // Longer than two cycles so the link domain also sees reset
      repeat (26) @(negedge clk);
      rst_b = 1'h1;
      repeat (30) @(negedge clk);
      check({7'h00, port_busy}, 8'h00);
      ptr = 32'(cnc_pkg::PTR_RST);
      rd_data(2);
      for (int s = 0; s < 2; s++) begin
         asel = s[0];
         wr_ptr($random(seed));
         wr_data(3);
         u_cnc_mst.stop();
         wr_ptr(ptr - 3);
         rd_data(4);
         rd_data(2);
         u_cnc_mst.start();
         send({cnc_pkg::ADDR_HI, !asel, 1'h0}, 1'h0);
         send(8'h5a, 1'h0);
         u_cnc_mst.stop();
         u_cnc_mst.start();
         send({6'h35, asel, 1'h0}, 1'h0);
         u_cnc_mst.stop();
      end
      // Hold the clock low in the address acknowledge with the oscillator off, then on
      osc_dis = 1'h1;
      ab = {cnc_pkg::ADDR_HI, asel, 1'h0};
      u_cnc_mst.start();
      for (int i = 7; i >= 0; i--) begin
         u_cnc_mst.bit_io(ab[i], ack);
      end
      repeat (425) @(negedge clk);
      check({7'h00, port_timeout}, 8'h00);
      check({7'h00, sda_oe}, 8'h01);
      check({7'h00, port_busy}, 8'h01);
      osc_dis = 1'h0;
      repeat (400) @(negedge clk);
      check({7'h00, port_timeout}, 8'h01);
      check({7'h00, sda_oe}, 8'h00);
      check({7'h00, port_busy}, 8'h00);
      u_cnc_mst.bit_io(1'h1, ack);
      u_cnc_mst.stop();
      wr_ptr($random(seed));
      wr_data(2);
      u_cnc_mst.stop();
      repeat (50) @(negedge clk);
      for (int a = 0; a < 256; a++) begin
         check(regs[a], ref_mem[a][7:0]);
      end
      report_and_stop();
   end
   initial begin
      repeat (80000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule
